// File: logic/pcd_override.v
// Port C and port D alternate-function override logic
`timescale 1ns/100ps
`include "pcd_map.vh"
// Notes on behaviour
// - Upper port C: timer compares, input enables
// - C2 input enable by source eleven only
// - D7 flow control: input, pull-up from port
// - Transmitter gated by sampled D7 level
// - D6 forced output carrying request-to-send
// - D5 clock direction follows direction bit
// - D5 clock only in synchronous mode
// - Transmitter forces D3 output, pull-up off
// - Receiver forces D2 input, feeds receive
// - D2 pull-up from port bit, disable qualified
// - D0 narrow compare B when direction set
// - Same D0 path carries PWM waveform
// - Port D feeds interrupts; input enables held
// - Global disable kills every pull-up
module pcd_override (
    input wire I_CLK, // System clock, 20 MHz
    input wire I_SRST, // Synchronous reset, active high
    input wire [7:0] I_PORTC, // Port C data register
    input wire [7:0] I_DDRC, // Port C direction register
    input wire [7:0] I_PORTD, // Port D data register
    input wire [7:0] I_DDRD, // Port D direction register
    input wire I_GLOBAL_PULLUP_DISABLE, // Global pull-up disable
    input wire [7:0] I_PINC, // Port C pad levels
    input wire [7:0] I_PIND, // Port D pad levels
    input wire I_WIDE_TIMER_COMPARE_A, // 16-bit timer compare A
    input wire I_WIDE_TIMER_COMPARE_A_EN, // Compare A output enable
    input wire I_WIDE_TIMER_COMPARE_B, // 16-bit timer compare B
    input wire I_WIDE_TIMER_COMPARE_B_EN, // Compare B output enable
    input wire I_NARROW_TIMER_COMPARE_B, // 8-bit timer compare B / PWM
    input wire I_NARROW_TIMER_COMPARE_B_EN, // 8-bit compare B output enable
    input wire I_EXT_IRQ_FOUR_EN, // External irq 4 enable
    input wire [3:0] I_PIN_CHANGE_C_EN, // Pin-change 8..11 enables
    input wire I_PIN_CHANGE_SRC_TWELVE_EN, // Pin-change 12 enable
    input wire [7:0] I_EXT_IRQ_D_EN, // External irq 0..7 enables
    input wire I_CTS_EN, // Transmit flow control active
    input wire I_RTS_EN, // Receive flow control active
    input wire I_RTS_OUT, // Request-to-send level from receiver
    input wire I_RTS_OUT_EN, // Request-to-send output enable
    input wire I_SERIAL_SYNC_MODE, // Serial port in synchronous mode
    input wire I_SERIAL_SYNC_CLOCK_OUT, // Serial clock to drive out
    input wire I_SERIAL_TX_ENABLE, // Transmitter enable
    input wire I_SERIAL_TX_LINE, // Transmit data
    input wire I_SERIAL_RX_ENABLE, // Receiver enable
    input wire I_COMPARATOR_NEG_EN, // Comparator negative input enable
    input wire I_COMPARATOR_POS_EN, // Comparator positive input enable
    output reg [7:0] O_PULLUP_C, // Port C pull-up on
    output reg [7:0] O_DIR_C, // Port C output enable
    output reg [7:0] O_OUT_C, // Port C driven value
    output reg [7:0] O_INPUT_EN_C, // Port C digital input enable
    output reg [7:0] O_PULLUP_D, // Port D pull-up on
    output reg [7:0] O_DIR_D, // Port D output enable
    output reg [7:0] O_OUT_D, // Port D driven value
    output reg [7:0] O_INPUT_EN_D, // Port D digital input enable
    output reg O_TX_ALLOW, // Transmitter may send
    output reg O_SERIAL_RX_LINE, // Receive data from pad
    output reg O_SERIAL_SYNC_CLOCK_IN, // Serial clock taken from pad
    output reg O_SERIAL_SYNC_CLOCK_DRIVE, // Device drives serial clock
    output reg [7:0] O_EXT_IRQ_D, // External irq 0..7 pad levels
    output reg O_EXT_IRQ_FOUR, // External irq 4 pad level
    output reg [4:0] O_PIN_CHANGE_C, // Pin-change 8..12 pad levels
    output reg O_NARROW_TIMER_COUNT_IN // 8-bit timer count input level
);

    // Override pairs per pin
    reg [7:0] pullup_override_en_c, pullup_override_val_c;
    reg [7:0] dir_override_en_c, dir_override_val_c;
    reg [7:0] out_value_override_en_c, out_value_override_val_c;
    reg [7:0] input_en_override_en_c, input_en_override_val_c;
    reg [7:0] pullup_override_en_d, pullup_override_val_d;
    reg [7:0] dir_override_en_d, dir_override_val_d;
    reg [7:0] out_value_override_en_d, out_value_override_val_d;
    reg [7:0] input_en_override_en_d, input_en_override_val_d;
    reg [7:0] pullup_c_d, dir_c_d, out_c_d, ien_c_d;
    reg [7:0] pullup_d_d, dir_d_d, out_d_d, ien_d_d;
    reg sync_clk_active; // Clock function owns D5

    // Select override where enabled, register value otherwise
    function [7:0] pick;
        input [7:0] en;
        input [7:0] ov;
        input [7:0] normal;
        begin
            pick = (en & ov) | (~en & normal);
        end
    endfunction

    // Port pull-up request: input with port bit set, not disabled
    function [7:0] pull_req;
        input [7:0] dir;
        input [7:0] port;
        input dis;
        begin
            pull_req = ~dir & port & {8{~dis}};
        end
    endfunction

    // Port C override table
    always @* begin
        pullup_override_en_c = `PCD_ZERO8;
        pullup_override_val_c = `PCD_ZERO8;
        dir_override_en_c = `PCD_ZERO8;
        dir_override_val_c = `PCD_ZERO8;
        out_value_override_en_c = `PCD_ZERO8;
        out_value_override_val_c = `PCD_ZERO8;
        input_en_override_en_c = `PCD_ZERO8;
        input_en_override_val_c = `PCD_ZERO8;
        out_value_override_en_c[`PCD_BIT6] = I_WIDE_TIMER_COMPARE_A_EN;
        out_value_override_val_c[`PCD_BIT6] = I_WIDE_TIMER_COMPARE_A;
        out_value_override_en_c[`PCD_BIT5] = I_WIDE_TIMER_COMPARE_B_EN;
        out_value_override_val_c[`PCD_BIT5] = I_WIDE_TIMER_COMPARE_B;
        input_en_override_en_c[`PCD_BIT7] = I_EXT_IRQ_FOUR_EN;
        input_en_override_en_c[`PCD_BIT6] = I_PIN_CHANGE_C_EN[0];
        input_en_override_en_c[`PCD_BIT5] = I_PIN_CHANGE_C_EN[1];
        input_en_override_en_c[`PCD_BIT4] = I_PIN_CHANGE_C_EN[2];
        // source eleven on C2; C1/C0 untouched
        input_en_override_en_c[`PCD_BIT2] = I_PIN_CHANGE_C_EN[3];
        input_en_override_val_c = input_en_override_en_c;
    end

    // Port D override table
    always @* begin
        sync_clk_active = I_SERIAL_SYNC_MODE;
        pullup_override_en_d = `PCD_ZERO8;
        pullup_override_val_d = `PCD_ZERO8;
        dir_override_en_d = `PCD_ZERO8;
        dir_override_val_d = `PCD_ZERO8;
        out_value_override_en_d = `PCD_ZERO8;
        out_value_override_val_d = `PCD_ZERO8;
        input_en_override_en_d = `PCD_ZERO8;
        input_en_override_val_d = `PCD_ZERO8;
        pullup_override_en_d[`PCD_BIT7] = I_CTS_EN;
        pullup_override_val_d[`PCD_BIT7] = I_PORTD[`PCD_BIT7] & ~I_GLOBAL_PULLUP_DISABLE;
        dir_override_en_d[`PCD_BIT7] = I_CTS_EN;
        pullup_override_en_d[`PCD_BIT6] = I_RTS_EN;
        dir_override_en_d[`PCD_BIT6] = I_RTS_EN;
        dir_override_val_d[`PCD_BIT6] = 1'b1;
        out_value_override_en_d[`PCD_BIT6] = I_RTS_OUT_EN;
        out_value_override_val_d[`PCD_BIT6] = I_RTS_OUT;
        out_value_override_en_d[`PCD_BIT5] = sync_clk_active & I_DDRD[`PCD_BIT5];
        out_value_override_val_d[`PCD_BIT5] = I_SERIAL_SYNC_CLOCK_OUT;
        pullup_override_en_d[`PCD_BIT3] = I_SERIAL_TX_ENABLE;
        dir_override_en_d[`PCD_BIT3] = I_SERIAL_TX_ENABLE;
        dir_override_val_d[`PCD_BIT3] = 1'b1;
        out_value_override_en_d[`PCD_BIT3] = I_SERIAL_TX_ENABLE;
        out_value_override_val_d[`PCD_BIT3] = I_SERIAL_TX_LINE;
        dir_override_en_d[`PCD_BIT2] = I_SERIAL_RX_ENABLE;
        // D2 pull-up still from port bit
        pullup_override_en_d[`PCD_BIT2] = I_SERIAL_RX_ENABLE;
        pullup_override_val_d[`PCD_BIT2] = I_PORTD[`PCD_BIT2] & ~I_GLOBAL_PULLUP_DISABLE;
        out_value_override_en_d[`PCD_BIT0] = I_NARROW_TIMER_COMPARE_B_EN & I_DDRD[`PCD_BIT0];
        out_value_override_val_d[`PCD_BIT0] = I_NARROW_TIMER_COMPARE_B;
        input_en_override_en_d = I_EXT_IRQ_D_EN;
        input_en_override_en_d[`PCD_BIT5] = I_EXT_IRQ_D_EN[`PCD_BIT5] | I_PIN_CHANGE_SRC_TWELVE_EN;
        input_en_override_val_d = `PCD_ONES8;
        // Comparator use switches digital input off
        input_en_override_en_d[`PCD_BIT2] = I_EXT_IRQ_D_EN[`PCD_BIT2] | I_COMPARATOR_NEG_EN;
        input_en_override_en_d[`PCD_BIT1] = I_EXT_IRQ_D_EN[`PCD_BIT1] | I_COMPARATOR_POS_EN;
        // interrupt beats comparator
        // An enabled interrupt must still see the pad, so it keeps the input on
        input_en_override_val_d[`PCD_BIT2] = ~I_COMPARATOR_NEG_EN | I_EXT_IRQ_D_EN[`PCD_BIT2];
        input_en_override_val_d[`PCD_BIT1] = ~I_COMPARATOR_POS_EN | I_EXT_IRQ_D_EN[`PCD_BIT1];
    end

    // Final pin controls
    always @* begin
        pullup_c_d = pick(pullup_override_en_c, pullup_override_val_c,
            pull_req(I_DDRC, I_PORTC, I_GLOBAL_PULLUP_DISABLE));
        dir_c_d = pick(dir_override_en_c, dir_override_val_c, I_DDRC);
        out_c_d = pick(out_value_override_en_c, out_value_override_val_c, I_PORTC);
        ien_c_d = pick(input_en_override_en_c, input_en_override_val_c, `PCD_ONES8);
        pullup_d_d = pick(pullup_override_en_d, pullup_override_val_d,
            pull_req(I_DDRD, I_PORTD, I_GLOBAL_PULLUP_DISABLE));
        dir_d_d = pick(dir_override_en_d, dir_override_val_d, I_DDRD);
        out_d_d = pick(out_value_override_en_d, out_value_override_val_d, I_PORTD);
        ien_d_d = pick(input_en_override_en_d, input_en_override_val_d, `PCD_ONES8);
    end

    // Registered outputs; one cycle behind the controls
    always @(posedge I_CLK) begin
        if (I_SRST) begin
            O_PULLUP_C <= `PCD_ZERO8;
            O_DIR_C <= `PCD_ZERO8;
            O_OUT_C <= `PCD_ZERO8;
            O_INPUT_EN_C <= `PCD_ZERO8;
            O_PULLUP_D <= `PCD_ZERO8;
            O_DIR_D <= `PCD_ZERO8;
            O_OUT_D <= `PCD_ZERO8;
            O_INPUT_EN_D <= `PCD_ZERO8;
            O_TX_ALLOW <= 1'b0;
            O_SERIAL_RX_LINE <= 1'b1;
            O_SERIAL_SYNC_CLOCK_IN <= 1'b0;
            O_SERIAL_SYNC_CLOCK_DRIVE <= 1'b0;
            O_EXT_IRQ_D <= `PCD_ZERO8;
            O_EXT_IRQ_FOUR <= 1'b0;
            O_PIN_CHANGE_C <= `PCD_ZERO5;
            O_NARROW_TIMER_COUNT_IN <= 1'b0;
        end else begin
            O_PULLUP_C <= pullup_c_d;
            O_DIR_C <= dir_c_d;
            O_OUT_C <= out_c_d;
            O_INPUT_EN_C <= ien_c_d;
            O_PULLUP_D <= pullup_d_d;
            O_DIR_D <= dir_d_d;
            O_OUT_D <= out_d_d;
            O_INPUT_EN_D <= ien_d_d;
            O_TX_ALLOW <= ~I_CTS_EN | ~I_PIND[`PCD_BIT7];
            O_SERIAL_RX_LINE <= I_SERIAL_RX_ENABLE ? I_PIND[`PCD_BIT2] : 1'b1;
            O_SERIAL_SYNC_CLOCK_IN <= sync_clk_active & ~I_DDRD[`PCD_BIT5] & I_PIND[`PCD_BIT5];
            O_SERIAL_SYNC_CLOCK_DRIVE <= sync_clk_active & I_DDRD[`PCD_BIT5];
            O_EXT_IRQ_D <= I_PIND & ien_d_d;
            O_EXT_IRQ_FOUR <= I_PINC[`PCD_BIT7] & ien_c_d[`PCD_BIT7];
            O_PIN_CHANGE_C <= {I_PIND[`PCD_BIT5] & ien_d_d[`PCD_BIT5],
                I_PINC[`PCD_BIT2], I_PINC[`PCD_BIT4], I_PINC[`PCD_BIT5], I_PINC[`PCD_BIT6]};
            O_NARROW_TIMER_COUNT_IN <= I_PIND[`PCD_BIT7];
        end
    end

endmodule // pcd_override

// File: logic/pcd_map.vh
// Bit positions and constants for the port C/D alternate override mux
`ifndef PCD_MAP_VH
`define PCD_MAP_VH
`define PCD_ZERO8 8'h00
`define PCD_ZERO5 5'h00
`define PCD_ONES8 8'hff
`define PCD_BIT0 0
`define PCD_BIT1 1
`define PCD_BIT2 2
`define PCD_BIT3 3
`define PCD_BIT4 4
`define PCD_BIT5 5
`define PCD_BIT6 6
`define PCD_BIT7 7
`endif

// File: tb/pcd_override_asserts.sv
// Checker watching the port C/D override block at its ports
`timescale 1ns/100ps
module pcd_chk (
    input wire I_CLK, I_SRST, // Clock and sync reset
    input wire [7:0] I_PORTC, I_DDRC, I_PORTD, I_DDRD, I_PIND, I_EXT_IRQ_D_EN, // Port regs, pads
    input wire I_GLOBAL_PULLUP_DISABLE, I_SERIAL_TX_ENABLE, I_SERIAL_TX_LINE, I_SERIAL_RX_ENABLE, // Serial
    input wire I_CTS_EN, I_RTS_EN, I_RTS_OUT, I_RTS_OUT_EN, I_SERIAL_SYNC_MODE, // Flow control, mode
    input wire I_NARROW_TIMER_COMPARE_B, I_NARROW_TIMER_COMPARE_B_EN, // Narrow timer
    input wire I_WIDE_TIMER_COMPARE_A, I_WIDE_TIMER_COMPARE_A_EN, // Wide timer
    input wire [7:0] O_DIR_D, O_OUT_D, O_PULLUP_D, O_PULLUP_C, O_DIR_C, O_OUT_C, O_INPUT_EN_D, O_EXT_IRQ_D, // Pins
    input wire O_SERIAL_RX_LINE, O_TX_ALLOW, O_SERIAL_SYNC_CLOCK_DRIVE // Serial results
);
    // Outputs are registered, so each check looks one edge after its cause
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    a_tx_forces_out: assert property (I_SERIAL_TX_ENABLE |=> O_DIR_D[3] && !O_PULLUP_D[3]
        && O_OUT_D[3] == $past(I_SERIAL_TX_LINE)) else $error("tx pin not overridden");
    a_rx_forces_in: assert property (I_SERIAL_RX_ENABLE |=> !O_DIR_D[2]
        && O_SERIAL_RX_LINE == $past(I_PIND[2])
        && O_PULLUP_D[2] == $past(I_PORTD[2] & !I_GLOBAL_PULLUP_DISABLE)) else $error("rx pin not overridden");
    a_cts_gates_tx: assert property (I_CTS_EN |=> !O_DIR_D[7] && O_TX_ALLOW == !$past(I_PIND[7])
        && O_PULLUP_D[7] == $past(I_PORTD[7] & !I_GLOBAL_PULLUP_DISABLE)) else $error("cts pin wrong");
    a_rts_drives_pin: assert property (I_RTS_EN && I_RTS_OUT_EN |=> O_DIR_D[6]
        && O_OUT_D[6] == $past(I_RTS_OUT)) else $error("rts pin wrong");
    a_pud_kills_all: assert property (I_GLOBAL_PULLUP_DISABLE [*2] |->
        O_PULLUP_C == 8'h00 && O_PULLUP_D == 8'h00) else $error("pull-up on while disabled");
    a_sync_clock_gate: assert property (1 |=>
        O_SERIAL_SYNC_CLOCK_DRIVE == $past(I_SERIAL_SYNC_MODE & I_DDRD[5])) else $error("clock drive wrong");
    a_narrow_pwm_out: assert property (I_NARROW_TIMER_COMPARE_B_EN && I_DDRD[0] |=>
        O_OUT_D[0] == $past(I_NARROW_TIMER_COMPARE_B)) else $error("narrow compare not on pin");
    a_wide_cmp_out: assert property (I_WIDE_TIMER_COMPARE_A_EN |=>
        O_OUT_C[6] == $past(I_WIDE_TIMER_COMPARE_A)) else $error("wide compare not on pin");
    a_low_c_plain: assert property (1 |=> O_DIR_C[1:0] == $past(I_DDRC[1:0])
        && O_OUT_C[1:0] == $past(I_PORTC[1:0])) else $error("low port c overridden");
    a_irq_input_on: assert property (I_EXT_IRQ_D_EN[4] |=> O_INPUT_EN_D[4]
        && O_EXT_IRQ_D[4] == $past(I_PIND[4])) else $error("irq input lost");
    a_irq_keeps_d2: assert property (I_EXT_IRQ_D_EN[2] |=> O_INPUT_EN_D[2])
        else $error("irq input on d2 lost");
endmodule // pcd_chk
bind pcd_override pcd_chk u_chk (.*);

// File: tb/pcd_periph_model.sv
// Stand-in for the timers and serial port that feed the override block
`timescale 1ns/100ps
module pcd_periph_model (
    input wire clk, // System clock
    input wire srst, // Sync reset
    input wire [2:0] duty, // PWM duty in eighths
    output wire cmp_a, cmp_b, pwm_b, tx_line, rts_out, sck_out // Peripheral levels
);
    logic [2:0] cnt_q = 3'h0; // Free-running phase
    // Step on the falling edge so the block always samples settled levels
    always @(negedge clk) begin
        cnt_q <= srst ? 3'h0 : cnt_q + 3'h1;
    end
    assign cmp_a = cnt_q[0]; // Toggles every cycle
    assign cmp_b = cnt_q[1];
    assign pwm_b = cnt_q < duty;
    assign tx_line = cnt_q[1] ^ cnt_q[0]; // Changes often, exposes a stuck pin
    assign rts_out = cnt_q[2];
    assign sck_out = cnt_q[0];
endmodule // pcd_periph_model

// File: tb/pcd_override_tb.sv
// Self-checking bench for the port C/D override block
`timescale 1ns/100ps
module pcd_override_tb;
    logic I_CLK = 1'b0, I_SRST = 1'b1, I_GLOBAL_PULLUP_DISABLE = 1'b0, I_EXT_IRQ_FOUR_EN = 1'b0;
    logic [7:0] I_PORTC = 8'h00, I_DDRC = 8'h00, I_PORTD = 8'h00, I_DDRD = 8'h00;
    logic [7:0] I_PINC = 8'h00, I_PIND = 8'h00, I_EXT_IRQ_D_EN = 8'h00;
    logic I_WIDE_TIMER_COMPARE_A_EN = 1'b0, I_WIDE_TIMER_COMPARE_B_EN = 1'b0, I_NARROW_TIMER_COMPARE_B_EN = 1'b0;
    logic [3:0] I_PIN_CHANGE_C_EN = 4'h0;
    logic I_PIN_CHANGE_SRC_TWELVE_EN = 1'b0, I_CTS_EN = 1'b0, I_RTS_EN = 1'b0, I_RTS_OUT_EN = 1'b0;
    logic I_SERIAL_SYNC_MODE = 1'b0, I_SERIAL_TX_ENABLE = 1'b0, I_SERIAL_RX_ENABLE = 1'b0;
    logic I_COMPARATOR_NEG_EN = 1'b0, I_COMPARATOR_POS_EN = 1'b0;
    logic [2:0] duty = 3'h3; // Partner PWM duty
    wire I_WIDE_TIMER_COMPARE_A, I_WIDE_TIMER_COMPARE_B, I_NARROW_TIMER_COMPARE_B;
    wire I_SERIAL_TX_LINE, I_RTS_OUT, I_SERIAL_SYNC_CLOCK_OUT;
    wire [7:0] O_PULLUP_C, O_DIR_C, O_OUT_C, O_INPUT_EN_C, O_PULLUP_D, O_DIR_D, O_OUT_D, O_INPUT_EN_D, O_EXT_IRQ_D;
    wire O_TX_ALLOW, O_SERIAL_RX_LINE, O_SERIAL_SYNC_CLOCK_IN, O_SERIAL_SYNC_CLOCK_DRIVE;
    wire O_EXT_IRQ_FOUR, O_NARROW_TIMER_COUNT_IN;
    wire [4:0] O_PIN_CHANGE_C;
    int n_mismatch = 0, cmp_count = 0;
    pcd_override u_dut (.*);
    pcd_periph_model u_periph (.clk(I_CLK), .srst(I_SRST), .duty(duty), .cmp_a(I_WIDE_TIMER_COMPARE_A),
        .cmp_b(I_WIDE_TIMER_COMPARE_B), .pwm_b(I_NARROW_TIMER_COMPARE_B), .tx_line(I_SERIAL_TX_LINE),
        .rts_out(I_RTS_OUT), .sck_out(I_SERIAL_SYNC_CLOCK_OUT));
    always #25 I_CLK = ~I_CLK; // 20 MHz
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Let the capturing edge land before looking
    task automatic tick;
        @(posedge I_CLK);
        #1;
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        n_mismatch++;
        report_and_stop;
    end
    initial begin
        repeat (10) @(posedge I_CLK);
        #1;
        chk("reset", 8'h01, {O_DIR_D[6:0], O_SERIAL_RX_LINE});
        for (int p = 0; p < 2; p++) begin
            @(negedge I_CLK);
            I_SRST = 1'b0;
            {I_PORTD, I_DDRD, I_PORTC, I_DDRC} = {8'hf0, 8'h3c, 8'h97, 8'h35};
            I_GLOBAL_PULLUP_DISABLE = p[0];
            tick;
            chk("pullup d", p ? 8'h00 : 8'hc0, O_PULLUP_D);
            chk("pullup c", p ? 8'h00 : 8'h82, O_PULLUP_C);
            chk("dir c", 8'h35, O_DIR_C);
            chk("out c", 8'h97, O_OUT_C);
        end
        @(negedge I_CLK);
        {I_PORTD, I_DDRD} = {8'hff, 8'h0c};
        {I_SERIAL_TX_ENABLE, I_SERIAL_RX_ENABLE, I_CTS_EN, I_RTS_EN, I_RTS_OUT_EN} = 5'h1f;
        // Transmit, receive and flow-control overrides at once, pads and disable walked
        for (int k = 0; k < 8; k++) begin
            @(negedge I_CLK);
            I_PIND = {k[0], 4'h0, k[1], 2'h0};
            I_GLOBAL_PULLUP_DISABLE = k[2];
            tick;
            chk("dir d", 8'h48, O_DIR_D);
            chk("pullup d", k[2] ? 8'h00 : 8'hb7, O_PULLUP_D);
            chk("out d", {1'b1, I_RTS_OUT, 2'h3, I_SERIAL_TX_LINE, 3'h7}, O_OUT_D);
            chk("serial in", {6'h0, ~k[0], k[1]}, {6'h0, O_TX_ALLOW, O_SERIAL_RX_LINE});
        end
        @(negedge I_CLK);
        {I_SERIAL_TX_ENABLE, I_SERIAL_RX_ENABLE, I_CTS_EN, I_RTS_EN, I_RTS_OUT_EN} = 5'h00;
        for (int s = 0; s < 8; s++) begin
            @(negedge I_CLK);
            {I_SERIAL_SYNC_MODE, I_DDRD[5], I_PIND[5]} = s[2:0];
            tick;
            chk("sync clock", {4'h0, (s[2] & s[1]) ? I_SERIAL_SYNC_CLOCK_OUT : 1'b1, s[2] & s[1],
                s[2] & ~s[1] & s[0], 1'b1}, {4'h0, O_OUT_D[5], O_SERIAL_SYNC_CLOCK_DRIVE,
                O_SERIAL_SYNC_CLOCK_IN, O_SERIAL_RX_LINE});
            chk("dir d", {2'h0, s[1], 5'h0c}, O_DIR_D);
        end
        for (int t = 0; t < 8; t++) begin
            @(negedge I_CLK);
            {I_WIDE_TIMER_COMPARE_A_EN, I_NARROW_TIMER_COMPARE_B_EN, I_DDRD[0]} = t[2:0];
            I_WIDE_TIMER_COMPARE_B_EN = t[0];
            duty = t[2:0];
            tick;
            chk("wide cmp", {6'h0, t[2] ? I_WIDE_TIMER_COMPARE_A : 1'b0, t[0] ? I_WIDE_TIMER_COMPARE_B : 1'b0},
                {6'h0, O_OUT_C[6:5]});
            chk("narrow cmp", {7'h0, (t[1] & t[0]) ? I_NARROW_TIMER_COMPARE_B : 1'b1}, {7'h0, O_OUT_D[0]});
        end
        @(negedge I_CLK);
        {I_EXT_IRQ_D_EN, I_PIND, I_PINC} = {8'hff, 8'ha5, 8'hd4};
        {I_COMPARATOR_NEG_EN, I_COMPARATOR_POS_EN, I_EXT_IRQ_FOUR_EN, I_PIN_CHANGE_C_EN} = 7'h7f;
        I_PIN_CHANGE_SRC_TWELVE_EN = 1'b1;
        tick;
        chk("irq d", 8'ha5, O_EXT_IRQ_D);
        chk("in en d", 8'hff, O_INPUT_EN_D);
        chk("in en c", 8'hff, O_INPUT_EN_C);
        chk("pin change", 8'h1d, {3'h0, O_PIN_CHANGE_C});
        chk("irq four", 8'h03, {6'h0, O_EXT_IRQ_FOUR, O_NARROW_TIMER_COUNT_IN});
        // Comparators alone switch D2/D1 input off
        @(negedge I_CLK);
        I_EXT_IRQ_D_EN = 8'h00;
        tick;
        chk("cmp in en d", 8'hf9, O_INPUT_EN_D);
        chk("cmp irq d", 8'ha1, O_EXT_IRQ_D);
        @(negedge I_CLK);
        I_SRST = 1'b1;
        tick;
        chk("mid reset", 8'h01, {O_OUT_D[6:0], O_SERIAL_RX_LINE});
        @(negedge I_CLK);
        I_SRST = 1'b0;
        tick;
        chk("after reset", {2'h3, I_SERIAL_SYNC_CLOCK_OUT, 4'hf, I_NARROW_TIMER_COMPARE_B}, O_OUT_D);
        report_and_stop;
    end
endmodule // pcd_override_tb
